// [core/cfg_pkg.sv]
// Shared constants, states and carrier structs of the daisy-chain configuration loader.
package cfg_pkg;

  localparam int SYS_CLK_MHZ = 40;
  localparam int REPROG_LOW_NS = 6000;
  localparam int REPROG_LOW_CYC = (REPROG_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 9;

  localparam int PREAMBLE_W = 11;
  localparam logic [PREAMBLE_W-1:0] PREAMBLE = 11'h7f2;
  localparam int LEN_W = 24;
  localparam int LEN_IDX_W = 5;
  localparam logic [LEN_IDX_W-1:0] LEN_LAST = 5'h17;
  localparam int WORD_W = 8;
  localparam int BIT_IDX_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int MODE_W = 2;
  localparam int KCNT_W = 3;
  localparam int SYNC_W = 7;

  localparam int PROGRAM_BITS_DEFAULT = 14779;
  localparam int START_CLOCKS_DEFAULT = 4;

  typedef enum logic [2:0] {L_HUNT, L_LEN, L_DATA, L_PASS, L_START, L_DONE} link_state_e;
  typedef enum logic [2:0] {S_CLEAR, S_RELEASE, S_LOAD, S_SETTLE, S_RUN} sys_state_e;

  typedef struct packed {
    link_state_e state;
    logic [PREAMBLE_W-1:0] pre;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] mem_bits;
    logic [LEN_IDX_W-1:0] len_idx;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [WORD_W-1:0] word;
    logic [1:0][WORD_W-1:0] hold;
    logic tgl;
    logic [KCNT_W-1:0] kcnt;
    logic drive_high;
    logic pass_bit;
    logic done;
    logic ack;
  } link_s;

  typedef struct packed {
    sys_state_e state;
    logic [TIMER_W-1:0] timer;
    logic armed;
    logic held;
    logic watch_prev;
    logic [MODE_W-1:0] mode;
    logic tgl_prev;
    logic lost;
    logic erase;
    logic oe_b;
    logic configured;
    logic pin_level;
  } sys_s;

  localparam link_s LINK_RESET = '{state: L_HUNT, drive_high: 1'b1, default: '0};
  localparam sys_s SYS_RESET = '{state: S_CLEAR, erase: 1'b1, default: '0};

endpackage : cfg_pkg

// [core/cfg_word_fifo.sv]
// Synchronous word FIFO with a registered read port.
`timescale 1ns/1ps
module cfg_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push;
  logic pop;

  assign in_ready = count != (AW + 1)'(DEPTH);

  always_comb begin
    push = in_valid && in_ready;
    pop = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_out_valid = out_valid;
    next_out_data = out_data;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_out_valid = 1'b0;
    end else begin
      if (push) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
        next_out_data = mem[rd_ptr];
        next_out_valid = 1'b1;
      end else if (out_ready) begin
        next_out_valid = 1'b0;
      end
      next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // The array carries no reset; only the pointers define what is valid.
  always_ff @(posedge sys_clk) begin
    if (ce && !flush && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

endmodule : cfg_word_fifo

// [core/daisy_cfg_loader.sv]
// Serial daisy-chain configuration loader with length-count start-up and reprogram detection.
`timescale 1ns/1ps
module daisy_cfg_loader #(
  parameter int PROGRAM_BITS = cfg_pkg::PROGRAM_BITS_DEFAULT,
  parameter int START_CLOCKS = cfg_pkg::START_CLOCKS_DEFAULT
) (
  // System clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Configuration link
  input wire logic cfg_clk,
  input wire logic cfg_din,
  output logic cfg_dout,
  // Control pins
  input wire logic done_program_pin_in,
  output logic done_program_pin_out,
  output logic done_program_pin_oe_b,
  input wire logic reset_pin,
  input wire logic [cfg_pkg::MODE_W-1:0] mode_pin,
  // Configuration memory side
  output logic cfg_erase,
  output logic [cfg_pkg::WORD_W-1:0] mem_word,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic cfg_done,
  output logic [cfg_pkg::MODE_W-1:0] cfg_mode,
  output logic word_lost
);

  function automatic logic [cfg_pkg::LEN_W-1:0] inc_count(input logic [cfg_pkg::LEN_W-1:0] v);
    return v + 24'h000001;
  endfunction : inc_count

  // Link domain.
  cfg_pkg::link_s link;
  cfg_pkg::link_s next_link;
  cfg_pkg::sys_s sys;
  cfg_pkg::sys_s next_sys;
  logic ce_l1;
  logic ce_l2;
  logic req_l1;
  logic req_l2;
  logic next_dout;
  logic [cfg_pkg::LEN_W-1:0] new_cnt;
  logic [cfg_pkg::LEN_W-1:0] new_bits;
  logic [cfg_pkg::WORD_W-1:0] new_word;

  always_ff @(posedge cfg_clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_l1 <= 1'b0;
      ce_l2 <= 1'b0;
      req_l1 <= 1'b1;
      req_l2 <= 1'b1;
    end else begin
      ce_l1 <= ce;
      ce_l2 <= ce_l1;
      req_l1 <= sys.erase;
      req_l2 <= req_l1;
    end
  end

  always_comb begin
    new_cnt = inc_count(link.cnt);
    new_bits = inc_count(link.mem_bits);
    new_word = {link.word[cfg_pkg::WORD_W-2:0], cfg_din};
    next_link = link;
    if (req_l2) begin
      next_link = cfg_pkg::LINK_RESET;
      next_link.ack = 1'b1;
    end else begin
      next_link.ack = 1'b0;
      if (ce_l2) begin
        next_link.pass_bit = cfg_din;
        unique case (link.state)
          cfg_pkg::L_HUNT: begin
            next_link.pre = {link.pre[cfg_pkg::PREAMBLE_W-2:0], cfg_din};
            next_link.drive_high = 1'b0;
            if ({link.pre[cfg_pkg::PREAMBLE_W-2:0], cfg_din} == cfg_pkg::PREAMBLE) begin
              next_link.state = cfg_pkg::L_LEN;
              next_link.cnt = cfg_pkg::LEN_W'(cfg_pkg::PREAMBLE_W);
              next_link.len_idx = '0;
            end
          end
          cfg_pkg::L_LEN: begin
            next_link.len = {link.len[cfg_pkg::LEN_W-2:0], cfg_din};
            next_link.cnt = new_cnt;
            next_link.len_idx = link.len_idx + 1'b1;
            if (link.len_idx == cfg_pkg::LEN_LAST) begin
              // The last length bit is still forwarded; data out goes high from the first frame bit.
              next_link.state = cfg_pkg::L_DATA;
            end
          end
          cfg_pkg::L_DATA: begin
            next_link.word = new_word;
            next_link.drive_high = 1'b1;
            next_link.bit_idx = link.bit_idx + 1'b1;
            next_link.mem_bits = new_bits;
            next_link.cnt = new_cnt;
            // A short last word is flushed as it stands so no frame bit is kept back.
            if (link.bit_idx == '1 || new_bits == cfg_pkg::LEN_W'(PROGRAM_BITS)) begin
              next_link.hold[!link.tgl] = new_word;
              next_link.tgl = !link.tgl;
              next_link.bit_idx = '0;
            end
            if (new_bits == cfg_pkg::LEN_W'(PROGRAM_BITS)) begin
              if (new_cnt == link.len) begin
                next_link.state = cfg_pkg::L_START;
                next_link.kcnt = '0;
              end else begin
                next_link.state = cfg_pkg::L_PASS;
              end
            end
          end
          cfg_pkg::L_PASS: begin
            next_link.cnt = new_cnt;
            next_link.drive_high = 1'b0;
            if (new_cnt == link.len) begin
              next_link.state = cfg_pkg::L_START;
              next_link.kcnt = '0;
            end
          end
          cfg_pkg::L_START: begin
            next_link.kcnt = link.kcnt + 1'b1;
            next_link.drive_high = 1'b1;
            if (link.kcnt == cfg_pkg::KCNT_W'(START_CLOCKS - 1)) begin
              next_link.state = cfg_pkg::L_DONE;
              next_link.done = 1'b1;
            end
          end
          cfg_pkg::L_DONE: begin
            next_link.done = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge cfg_clk or negedge rst_b) begin
    if (!rst_b) begin
      link <= cfg_pkg::LINK_RESET;
    end else begin
      link <= next_link;
    end
  end

  // Half a clock of lead lets the next device take the bit on its own rising edge.
  always_comb begin
    next_dout = link.drive_high ? 1'b1 : link.pass_bit;
  end

  always_ff @(negedge cfg_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_dout <= 1'b1;
    end else if (ce_l2) begin
      cfg_dout <= next_dout;
    end
  end

  // System domain.
  logic [cfg_pkg::SYNC_W-1:0] sync1;
  logic [cfg_pkg::SYNC_W-1:0] sync2;
  logic done_s;
  logic rst_s;
  logic [cfg_pkg::MODE_W-1:0] mode_s;
  logic ack_s;
  logic ldone_s;
  logic tgl_s;
  logic watch;
  logic push;
  logic fifo_ready;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {done_program_pin_in, reset_pin, mode_pin, link.ack, link.done, link.tgl};
      sync2 <= sync1;
    end
  end

  assign {done_s, rst_s, mode_s, ack_s, ldone_s, tgl_s} = sync2;

  always_comb begin
    watch = sys.held ? rst_s : done_s;
    push = 1'b0;
    next_sys = sys;
    if (ce) begin
      next_sys.tgl_prev = tgl_s;
      push = tgl_s != sys.tgl_prev;
      unique case (sys.state)
        cfg_pkg::S_CLEAR: begin
          next_sys.mode = mode_s;
          next_sys.lost = 1'b0;
          if (ack_s) begin
            next_sys.state = cfg_pkg::S_RELEASE;
          end
        end
        cfg_pkg::S_RELEASE: begin
          if (!ack_s) begin
            next_sys.state = cfg_pkg::S_LOAD;
          end
        end
        cfg_pkg::S_LOAD: begin
          if (ldone_s) begin
            next_sys.state = cfg_pkg::S_SETTLE;
            next_sys.timer = '0;
          end
        end
        cfg_pkg::S_SETTLE: begin
          // A done pin still low one window after release is taken as held low from outside.
          next_sys.timer = sys.timer + 1'b1;
          if (sys.timer == cfg_pkg::TIMER_W'(cfg_pkg::REPROG_LOW_CYC - 1)) begin
            next_sys.held = !done_s;
            next_sys.watch_prev = !done_s ? rst_s : done_s;
            next_sys.armed = 1'b0;
            next_sys.state = cfg_pkg::S_RUN;
          end
        end
        cfg_pkg::S_RUN: begin
          next_sys.watch_prev = watch;
          if (sys.watch_prev && !watch) begin
            next_sys.armed = 1'b1;
            next_sys.timer = '0;
          end else if (sys.armed) begin
            if (watch) begin
              next_sys.armed = 1'b0;
            end else if (sys.timer == cfg_pkg::TIMER_W'(cfg_pkg::REPROG_LOW_CYC)) begin
              next_sys.state = cfg_pkg::S_CLEAR;
              next_sys.armed = 1'b0;
            end else begin
              next_sys.timer = sys.timer + 1'b1;
            end
          end
        end
      endcase
      if (push && !fifo_ready) begin
        next_sys.lost = 1'b1;
      end
      next_sys.erase = next_sys.state == cfg_pkg::S_CLEAR;
      next_sys.configured = next_sys.state == cfg_pkg::S_RUN;
      next_sys.oe_b = next_sys.state == cfg_pkg::S_RUN || next_sys.state == cfg_pkg::S_SETTLE;
      next_sys.pin_level = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys <= cfg_pkg::SYS_RESET;
    end else begin
      sys <= next_sys;
    end
  end

  // Two hold buffers alternate, so a short last word cannot overwrite its predecessor mid-crossing.
  cfg_word_fifo #(.WIDTH(cfg_pkg::WORD_W), .DEPTH(cfg_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .flush(sys.erase),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(link.hold[tgl_s]),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data(mem_word)
  );

  assign cfg_erase = sys.erase;
  assign cfg_done = sys.configured;
  assign cfg_mode = sys.mode;
  assign word_lost = sys.lost;
  assign done_program_pin_out = sys.pin_level;
  assign done_program_pin_oe_b = sys.oe_b;

  a_reprog_expiry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys.state == cfg_pkg::S_RUN && sys.armed && !watch && ce && sys.timer == 9'h0f0 |=> sys.state == cfg_pkg::S_CLEAR)
    else $error("reprogram not started after long low");
  a_reprog_not_early: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys.state == cfg_pkg::S_RUN && sys.armed && sys.timer < 9'h0e8 |=> sys.state != cfg_pkg::S_CLEAR)
    else $error("reprogram started too early");
  a_reset_pin_arm: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys.state == cfg_pkg::S_RUN && sys.held && ce && $past(rst_s) && !rst_s |=> sys.armed)
    else $error("reset pin edge ignored while done held low");
  a_mode_sampled: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys.state == cfg_pkg::S_CLEAR && ce ##1 sys.state == cfg_pkg::S_CLEAR |-> sys.mode == $past(mode_s) && cfg_erase)
    else $error("mode not sampled in clear");
  a_erase_until_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys.state == cfg_pkg::S_CLEAR && !ack_s |=> cfg_erase && !mem_valid)
    else $error("erase dropped before link acknowledged");
  a_preamble_enter: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_HUNT && ce_l2 && {link.pre[9:0], cfg_din} == 11'h7f2 |=> link.state == cfg_pkg::L_LEN
    && link.cnt == 24'h00000b)
    else $error("preamble not recognised");
  a_length_capture: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_LEN && link.len_idx == 5'h17 && ce_l2 |=> link.state == cfg_pkg::L_DATA
    && link.len == $past({link.len[22:0], cfg_din}))
    else $error("length count not taken after 24 bits");
  a_header_forward: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_LEN && ce_l2 ##1 ce_l2 |-> cfg_dout == $past(cfg_din))
    else $error("header bit not forwarded");
  a_data_high: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_DATA && $past(link.state) == cfg_pkg::L_DATA && ce_l2 && $past(ce_l2) |-> cfg_dout)
    else $error("data out not high while loading");
  a_full_pass: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_DATA && ce_l2 && inc_count(link.mem_bits) == 24'(PROGRAM_BITS)
    && inc_count(link.cnt) != link.len |=> link.state == cfg_pkg::L_PASS)
    else $error("full memory did not pass data");
  a_count_compare: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2)
    link.state == cfg_pkg::L_PASS && ce_l2 && inc_count(link.cnt) == link.len |=> link.state == cfg_pkg::L_START)
    else $error("length compare missed");
  localparam int START_LAST = START_CLOCKS - 1;
  a_startup_clocks: assert property (@(posedge cfg_clk) disable iff (!rst_b || req_l2 || !ce_l2)
    $rose(link.state == cfg_pkg::L_START) |-> !link.done ##START_LAST !link.done ##1 link.done)
    else $error("start-up length wrong");

  c_preamble: cover property (@(posedge cfg_clk) disable iff (!rst_b) link.state == cfg_pkg::L_LEN);
  c_pass: cover property (@(posedge cfg_clk) disable iff (!rst_b) link.state == cfg_pkg::L_PASS);
  c_done: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(cfg_done));
  c_reprog: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(cfg_done) ##1 cfg_erase);

endmodule : daisy_cfg_loader

// [verif/cfg_stream_src.sv]
// Behavioural configuration bitstream source driving the link clock and serial data.
`timescale 1ns/1ps
module cfg_stream_src (
  // Link
  output logic cfg_clk,
  output logic cfg_din,
  input wire logic cfg_dout
);
  logic sent_q[$];
  logic dout_q[$];
  logic pay_q[$];
  logic last;
  int gap;

  initial begin
    cfg_clk = 1'b0;
    cfg_din = 1'b1;
    last = 1'b1;
    gap = 0;
  end

  // One clock per bit; with gap set the clock stands low between bits and the line shows the inverse bit.
  task automatic send_bit(input logic b);
    cfg_din = b;
    sent_q.push_back(b);
    #5 cfg_clk = 1'b1;
    #6 cfg_clk = 1'b0;
    #1 dout_q.push_back(cfg_dout);
    last = b;
    if (gap > 0) begin
      cfg_din = ~b;
      #(gap);
    end
  endtask : send_bit

  task automatic idle(input int n);
    repeat (n) send_bit(~last);
    cfg_din = ~last;
  endtask : idle

  task automatic frame(input int n_data, input int n_pass, input int n_start);
    logic [23:0] len;
    len = 24'(35 + n_data + n_pass);
    sent_q.delete();
    dout_q.delete();
    for (int i = 10; i >= 0; i--) send_bit(cfg_pkg::PREAMBLE[i]);
    for (int i = 23; i >= 0; i--) send_bit(len[i]);
    for (int i = 0; i < n_data + n_pass; i++) send_bit(pay_q[i]);
    repeat (n_start) send_bit(~last);
    cfg_din = ~last;
  endtask : frame
endmodule : cfg_stream_src

// [verif/daisy_cfg_loader_tb.sv]
// Self-checking bench for the daisy-chain configuration loader.
`timescale 1ns/1ps
module daisy_cfg_loader_tb;
  localparam int PBITS = 100;
  localparam int KCLK = 3;
  localparam int NPASS = 6;
  logic sys_clk, rst_b, ce, cfg_clk, cfg_din, cfg_dout;
  logic done_wire, done_out, done_oe_b, pull_low, reset_pin;
  logic [cfg_pkg::MODE_W-1:0] mode_pin, cfg_mode;
  logic cfg_erase, mem_valid, mem_ready, cfg_done, word_lost, rdy_en;
  logic [cfg_pkg::WORD_W-1:0] mem_word;
  logic [7:0] got_q[$];
  logic [7:0] exp_q[$];
  int seed, fails, num_checks;

  // Open-drain wire with a pull-up: low if the device or the bench pulls it.
  assign done_wire = (pull_low || (!done_oe_b && !done_out)) ? 1'b0 : 1'b1;

  daisy_cfg_loader #(.PROGRAM_BITS(PBITS), .START_CLOCKS(KCLK)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
    .cfg_clk(cfg_clk), .cfg_din(cfg_din), .cfg_dout(cfg_dout),
    .done_program_pin_in(done_wire), .done_program_pin_out(done_out),
    .done_program_pin_oe_b(done_oe_b), .reset_pin(reset_pin), .mode_pin(mode_pin),
    .cfg_erase(cfg_erase), .mem_word(mem_word), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .cfg_done(cfg_done), .cfg_mode(cfg_mode), .word_lost(word_lost)
  );

  cfg_stream_src src (.cfg_clk(cfg_clk), .cfg_din(cfg_din), .cfg_dout(cfg_dout));

  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    mem_ready <= rdy_en ? 1'($random(seed)) : 1'b0;
    if (mem_valid === 1'b1 && mem_ready === 1'b1) got_q.push_back(mem_word);
  end

  task automatic chk1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // The link needs clocks to finish the clear handshake, so clock idle bits until erase drops.
  task automatic open_link();
    int n;
    n = 0;
    while (cfg_erase !== 1'b0 && n < 100) begin
      src.idle(1);
      n++;
    end
    chk1(cfg_erase, 1'b0, "erase release");
    src.idle(4);
  endtask : open_link

  task automatic load(input logic hold_ready);
    logic [7:0] w;
    logic [7:0] m;
    int i;
    w = 8'h00;
    src.pay_q.delete();
    exp_q.delete();
    got_q.delete();
    rdy_en = !hold_ready;
    for (i = 0; i < PBITS + NPASS; i++) src.pay_q.push_back(1'($random(seed)));
    for (i = 0; i < PBITS; i++) begin
      w = {w[6:0], src.pay_q[i]};
      if (i % 8 == 7 || i == PBITS - 1) begin
        exp_q.push_back(w);
        w = 8'h00;
      end
    end
    open_link();
    src.frame(PBITS, NPASS, KCLK - 1);
    for (i = 0; i < 35 + PBITS + NPASS; i++) begin
      if (i < 35 || i >= 35 + PBITS) chk1(src.dout_q[i], src.sent_q[i], "forwarded bit");
      else chk1(src.dout_q[i], 1'b1, "own data high");
    end
    repeat (300) @(negedge sys_clk);
    chk1(cfg_done, 1'b0, "start before last clock");
    src.idle(1);
    i = 0;
    while (cfg_done !== 1'b1 && i < 400) begin
      @(negedge sys_clk);
      i++;
    end
    chk1(cfg_done, 1'b1, "start-up");
    chk1(done_oe_b, 1'b1, "done wire released");
    chk8({6'h00, cfg_mode}, {6'h00, mode_pin}, "mode");
    chk1(word_lost, hold_ready, "overflow flag");
    rdy_en = 1'b1;
    repeat (60) @(negedge sys_clk);
    chk1(got_q.size() == exp_q.size(), !hold_ready, "word count");
    if (hold_ready) chk1(got_q.size() >= cfg_pkg::FIFO_DEPTH, 1'b1, "fifo depth");
    for (i = 0; i < got_q.size() && i < exp_q.size(); i++) begin
      m = (i == exp_q.size() - 1 && PBITS % 8 != 0) ? 8'((1 << (PBITS % 8)) - 1) : 8'hff;
      chk8(got_q[i] & m, exp_q[i] & m, "memory word");
    end
  endtask : load

  task automatic pulse(input logic use_reset, input int len);
    @(posedge sys_clk);
    if (use_reset) reset_pin <= 1'b0;
    else pull_low <= 1'b1;
    repeat (len) @(posedge sys_clk);
    if (use_reset) reset_pin <= 1'b1;
    else pull_low <= 1'b0;
    @(negedge sys_clk);
  endtask : pulse

  initial begin
    seed = 1636;
    fails = 0;
    num_checks = 0;
    sys_clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    pull_low = 1'b0;
    reset_pin = 1'b1;
    rdy_en = 1'b0;
    mem_ready = 1'b0;
    mode_pin = 2'($random(seed));
    fork
      repeat (20) @(posedge sys_clk);
      src.idle(10);
    join
    chk1(cfg_dout, 1'b1, "reset dout");
    chk1(done_oe_b, 1'b0, "reset drives done low");
    chk1(done_out, 1'b0, "done level low");
    chk1(cfg_erase, 1'b1, "reset erase");
    chk1(cfg_done, 1'b0, "reset done");
    rst_b <= 1'b1;
    load(1'b0);
    pulse(1'b0, 150);
    repeat (300) @(negedge sys_clk);
    chk1(cfg_done, 1'b1, "short low ignored");
    @(posedge sys_clk);
    mode_pin <= 2'($random(seed));
    pulse(1'b0, 260);
    chk1(cfg_erase, 1'b1, "reprogram by done pin");
    chk1(cfg_done, 1'b0, "left run");
    @(posedge sys_clk);
    pull_low <= 1'b1;
    src.gap = 7;
    load(1'b1);
    pulse(1'b1, 260);
    chk1(cfg_erase, 1'b1, "reprogram by reset pin");
    repeat (5) @(negedge sys_clk);
    chk1(word_lost, 1'b0, "lost flag cleared");
    final_report();
  end

  initial begin
    #400000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : daisy_cfg_loader_tb
